// File: hdl/lael_pkg.sv
// Constants for the per-channel alarm and event latch block.
// Summary of operation
// - Status bit 7 shows live system alarm indication.
// - Status bit 6 shows live line alarm indication.
// - Status bit 5 shows test pattern synchronization.
// - Activate code flag after 40 ms or 5.1 s.
// - Deactivate code flag after 30 ms or 5.1 s.
// - Latch bits hold until written one; zero ignored.
// - Any unmasked set latch drives interrupt output.
// - Over-current latch: rising, or both edges if selected.
// - Clock-missing latch: rising, or both edges if selected.
// - Transmit loss latch: rising, or both edges if selected.
// - System and line loss latches share edge select bit 1.
// - Both alarm latches share edge select bit 6.
// - Pattern sync latch: rising, or both edges if selected.
// - Both loop code latches share edge select bit 0.
// - First latch also catches amplitude and jitter FIFO events.
// - Third latch catches violation, zeros, error, overflow events.
// - Mask bit one blocks source; masks are input ports, not reset here.
// - First latch sources come from line status bits.
package lael_pkg;

    localparam int          NUM_CH          = 16;
    localparam int          CH_W            = 4;
    localparam int          ADDR_W          = 11;
    localparam int          TMR_W           = 27;

    // Channel blocks: channel n (1..15) at block n-1, channel 0 at the top block.
    localparam logic [4:0]  CH0_BLOCK       = 5'h1F;
    localparam logic [4:0]  LAST_LOW_BLOCK  = 5'h0E;

    // Offsets inside a channel block.
    localparam logic [5:0]  OFF_STATUS      = 6'h1F;
    localparam logic [5:0]  OFF_LATCH_A     = 6'h20;
    localparam logic [5:0]  OFF_LATCH_B     = 6'h21;
    localparam logic [5:0]  OFF_LATCH_C     = 6'h22;

    // Implemented bit positions; the rest are reserved.
    localparam logic [7:0]  USED_STATUS     = 8'hE3;
    localparam logic [7:0]  USED_LATCH_A    = 8'hFF;
    localparam logic [7:0]  USED_LATCH_B    = 8'hE3;
    localparam logic [7:0]  USED_LATCH_C    = 8'h3F;

    localparam logic [7:0]  RST_STATUS      = 8'h00;
    localparam logic [7:0]  RST_LATCH       = 8'h00;

    // Edge select positions.
    localparam int          ES_LOOP         = 0;
    localparam int          ES_LOSS         = 1;
    localparam int          ES_TX_LOSS      = 2;
    localparam int          ES_TX_CLK       = 3;
    localparam int          ES_OVERCURRENT  = 4;
    localparam int          ES_PATTERN      = 5;
    localparam int          ES_ALARM        = 6;

    // Loop code persistence times; the long time is 5.1 s.
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          LOOP_UP_MS      = 40;
    localparam int          LOOP_DOWN_MS    = 30;
    localparam int          LOOP_LONG_MS    = 5100;
    localparam int          NS_PER_MS       = 1000000;
    localparam int          LOOP_UP_CYC     = LOOP_UP_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int          LOOP_DOWN_CYC   = LOOP_DOWN_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int          LOOP_LONG_CYC   = LOOP_LONG_MS * (NS_PER_MS / CLK_PERIOD_NS);

endpackage : lael_pkg

// File: hdl/lael_event_latch.sv
// Multi-channel alarm status, event latches and shared interrupt output.
`timescale 1ns/1ps
module lael_event_latch
    import lael_pkg::*;
#(
    parameter int UP_SHORT_CYC   = LOOP_UP_CYC,
    parameter int DOWN_SHORT_CYC = LOOP_DOWN_CYC,
    parameter int LONG_CYC       = LOOP_LONG_CYC
) (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    // Host register port.
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [ADDR_W-1:0]             reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    output      logic [7:0]                    reg_rdata,
    // Live line status per channel.
    input  wire logic [NUM_CH-1:0]             overcurrent_live,
    input  wire logic [NUM_CH-1:0]             tx_clock_missing_live,
    input  wire logic [NUM_CH-1:0]             tx_loss_live,
    input  wire logic [NUM_CH-1:0]             sys_loss_live,
    input  wire logic [NUM_CH-1:0]             line_loss_live,
    // Live alarm, pattern and loop code detector levels per channel.
    input  wire logic [NUM_CH-1:0]             sys_alarm_ind_live,
    input  wire logic [NUM_CH-1:0]             line_alarm_ind_live,
    input  wire logic [NUM_CH-1:0]             pattern_sync_live,
    input  wire logic [NUM_CH-1:0]             loop_code_up_seen,
    input  wire logic [NUM_CH-1:0]             loop_code_down_seen,
    input  wire logic [NUM_CH-1:0]             auto_loopback_on,
    // One-cycle event pulses per channel.
    input  wire logic [NUM_CH-1:0]             amplitude_ovf_evt,
    input  wire logic [NUM_CH-1:0]             tx_jitter_fifo_evt,
    input  wire logic [NUM_CH-1:0]             rx_jitter_fifo_evt,
    input  wire logic [NUM_CH-1:0]             sys_bipolar_viol_evt,
    input  wire logic [NUM_CH-1:0]             line_bipolar_viol_evt,
    input  wire logic [NUM_CH-1:0]             sys_excess_zero_evt,
    input  wire logic [NUM_CH-1:0]             line_excess_zero_evt,
    input  wire logic [NUM_CH-1:0]             pattern_error_evt,
    input  wire logic [NUM_CH-1:0]             err_counter_ovf_evt,
    // Mask and edge select settings per channel.
    input  wire logic [NUM_CH-1:0][7:0]        mask_a,
    input  wire logic [NUM_CH-1:0][7:0]        mask_b,
    input  wire logic [NUM_CH-1:0][7:0]        mask_c,
    input  wire logic [NUM_CH-1:0][7:0]        edge_sel,
    // Shared interrupt.
    output      logic                          irq
);

    logic [4:0]        blk;
    logic [5:0]        offset;
    logic              hit_ch;
    logic [CH_W-1:0]   ch_sel;
    logic [7:0]        status       [NUM_CH];
    logic [7:0]        latch_a      [NUM_CH];
    logic [7:0]        latch_b      [NUM_CH];
    logic [7:0]        latch_c      [NUM_CH];
    logic [NUM_CH-1:0] pend;
    logic [7:0]        next_rdata;
    logic              next_irq;

    assign blk    = reg_addr[10:6];
    assign offset = reg_addr[5:0];

    // Channel 0 sits in the top block so the low blocks run 1..15 in order.
    always_comb begin
        hit_ch = 1'b0;
        ch_sel = '0;
        if (blk == CH0_BLOCK) begin
            hit_ch = 1'b1;
        end else if (blk <= LAST_LOW_BLOCK) begin
            hit_ch = 1'b1;
            ch_sel = blk[3:0] + 4'h1;
        end
    end

    function automatic logic [7:0] edge_hit(input logic [7:0] cur, input logic [7:0] prev, input logic [7:0] sel);
        edge_hit = (cur & ~prev) | (sel & (cur ^ prev));
    endfunction : edge_hit

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic [TMR_W-1:0] up_cnt;
        logic [TMR_W-1:0] next_up_cnt;
        logic [TMR_W-1:0] dn_cnt;
        logic [TMR_W-1:0] next_dn_cnt;
        logic [TMR_W-1:0] up_lim;
        logic [TMR_W-1:0] dn_lim;
        logic [7:0]       live_a;
        logic [7:0]       next_live_a;
        logic [7:0]       prev_a;
        logic [7:0]       prev_status;
        logic [7:0]       next_status;
        logic [7:0]       sel_a;
        logic [7:0]       sel_b;
        logic [7:0]       set_a;
        logic [7:0]       set_b;
        logic [7:0]       set_c;
        logic [7:0]       clr_a;
        logic [7:0]       clr_b;
        logic [7:0]       clr_c;
        logic [7:0]       next_latch_a;
        logic [7:0]       next_latch_b;
        logic [7:0]       next_latch_c;
        logic             wr_ch;

        always_comb begin
            // The long limit applies while automatic loopback is on.
            up_lim = auto_loopback_on[i] ? TMR_W'(LONG_CYC) : TMR_W'(UP_SHORT_CYC);
            dn_lim = auto_loopback_on[i] ? TMR_W'(LONG_CYC) : TMR_W'(DOWN_SHORT_CYC);
            // Counters saturate at the limit; any drop of the code restarts them.
            next_up_cnt = '0;
            if (loop_code_up_seen[i]) begin
                next_up_cnt = (up_cnt < up_lim) ? up_cnt + 1'b1 : up_cnt;
            end
            next_dn_cnt = '0;
            if (loop_code_down_seen[i]) begin
                next_dn_cnt = (dn_cnt < dn_lim) ? dn_cnt + 1'b1 : dn_cnt;
            end
            next_status = {sys_alarm_ind_live[i],
                           line_alarm_ind_live[i],
                           pattern_sync_live[i],
                           3'b000,
                           loop_code_up_seen[i] && (up_cnt >= up_lim),
                           loop_code_down_seen[i] && (dn_cnt >= dn_lim)} & USED_STATUS;
            next_live_a = {3'b000, overcurrent_live[i], tx_clock_missing_live[i],
                           tx_loss_live[i], sys_loss_live[i], line_loss_live[i]};
            sel_a = {3'b000,
                     edge_sel[i][ES_OVERCURRENT],
                     edge_sel[i][ES_TX_CLK],
                     edge_sel[i][ES_TX_LOSS],
                     edge_sel[i][ES_LOSS], edge_sel[i][ES_LOSS]};
            sel_b = {edge_sel[i][ES_ALARM], edge_sel[i][ES_ALARM],
                     edge_sel[i][ES_PATTERN],
                     3'b000,
                     edge_sel[i][ES_LOOP], edge_sel[i][ES_LOOP]};
            set_a = edge_hit(live_a, prev_a, sel_a)
                  | {amplitude_ovf_evt[i], tx_jitter_fifo_evt[i], rx_jitter_fifo_evt[i], 5'b00000};
            set_b = edge_hit(status[i], prev_status, sel_b);
            set_c = {2'b00, sys_bipolar_viol_evt[i], line_bipolar_viol_evt[i],
                     sys_excess_zero_evt[i], line_excess_zero_evt[i],
                     pattern_error_evt[i], err_counter_ovf_evt[i]};
            wr_ch = reg_wr && hit_ch && (ch_sel == CH_W'(i));
            clr_a = (wr_ch && offset == OFF_LATCH_A) ? reg_wdata : 8'h00;
            clr_b = (wr_ch && offset == OFF_LATCH_B) ? reg_wdata : 8'h00;
            clr_c = (wr_ch && offset == OFF_LATCH_C) ? reg_wdata : 8'h00;
            // A set in the same cycle as its clear wins, so no event is lost.
            next_latch_a = ((latch_a[i] & ~clr_a) | set_a) & USED_LATCH_A;
            next_latch_b = ((latch_b[i] & ~clr_b) | set_b) & USED_LATCH_B;
            next_latch_c = ((latch_c[i] & ~clr_c) | set_c) & USED_LATCH_C;
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                up_cnt      <= '0;
                dn_cnt      <= '0;
                live_a      <= RST_STATUS;
                prev_a      <= RST_STATUS;
                status[i]   <= RST_STATUS;
                prev_status <= RST_STATUS;
                latch_a[i]  <= RST_LATCH;
                latch_b[i]  <= RST_LATCH;
                latch_c[i]  <= RST_LATCH;
            end else begin
                up_cnt      <= next_up_cnt;
                dn_cnt      <= next_dn_cnt;
                live_a      <= next_live_a;
                prev_a      <= live_a;
                status[i]   <= next_status;
                prev_status <= status[i];
                latch_a[i]  <= next_latch_a;
                latch_b[i]  <= next_latch_b;
                latch_c[i]  <= next_latch_c;
            end
        end

        // A mask bit of one keeps its latch off the interrupt.
        assign pend[i] = |(latch_a[i] & ~mask_a[i] & USED_LATCH_A)
                       | |(latch_b[i] & ~mask_b[i] & USED_LATCH_B)
                       | |(latch_c[i] & ~mask_c[i] & USED_LATCH_C);
    end

    always_comb begin
        next_irq   = |pend;
        next_rdata = reg_rdata;
        if (reg_rd) begin
            next_rdata = 8'h00;
            if (hit_ch) begin
                case (offset)
                    OFF_STATUS:  next_rdata = status[ch_sel];
                    OFF_LATCH_A: next_rdata = latch_a[ch_sel];
                    OFF_LATCH_B: next_rdata = latch_b[ch_sel];
                    OFF_LATCH_C: next_rdata = latch_c[ch_sel];
                    default:     next_rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq       <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            irq       <= next_irq;
            reg_rdata <= next_rdata;
        end
    end

endmodule : lael_event_latch

// File: verification/lael_event_latch_sva.sv
// Port assertions for the alarm and event latch block.
`timescale 1ns/1ps
module lael_event_latch_sva
    import lael_pkg::*;
(
    // Clock and reset.
    input wire logic                   clk,
    input wire logic                   arst_n,
    // Register port.
    input wire logic                   reg_rd,
    input wire logic [ADDR_W-1:0]      reg_addr,
    input wire logic [7:0]             reg_rdata,
    // Sources and masks.
    input wire logic [NUM_CH-1:0]      sys_alarm_ind_live,
    input wire logic [NUM_CH-1:0]      line_alarm_ind_live,
    input wire logic [NUM_CH-1:0]      pattern_sync_live,
    input wire logic [NUM_CH-1:0]      amplitude_ovf_evt,
    input wire logic [NUM_CH-1:0][7:0] mask_a,
    input wire logic [NUM_CH-1:0][7:0] mask_b,
    input wire logic [NUM_CH-1:0][7:0] mask_c,
    // Interrupt.
    input wire logic                   irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Channel 1 status read, the only channel watched live to keep this small.
    sequence rd_status1;
        reg_rd && reg_addr == 11'h01F;
    endsequence
    sequence amp_evt1;
        amplitude_ovf_evt[1] && !mask_a[1][7];
    endsequence
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");
    status_live_a: assert property (rd_status1 |=> reg_rdata[7:5] ==
        {$past(sys_alarm_ind_live[1], 2), $past(line_alarm_ind_live[1], 2), $past(pattern_sync_live[1], 2)})
        else $error("status live bits differ from inputs");
    status_rsv_a: assert property (rd_status1 |=> reg_rdata[4:2] == 3'h0) else $error("status reserved bits set");
    latchb_rsv_a: assert property (reg_rd && reg_addr[5:0] == OFF_LATCH_B |=> reg_rdata[4:2] == 3'h0)
        else $error("latch b reserved bits set");
    latchc_rsv_a: assert property (reg_rd && reg_addr[5:0] == OFF_LATCH_C |=> reg_rdata[7:6] == 2'h0)
        else $error("latch c reserved bits set");
    unmapped_zero_a: assert property (reg_rd && (reg_addr[5:0] < 6'h1F || reg_addr[5:0] > 6'h22)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    evt_irq_a: assert property (amp_evt1 |-> ##[1:3] irq) else $error("unmasked event gave no interrupt");
    masked_quiet_a: assert property (&{mask_a, mask_b, mask_c} [*2] |=> !irq)
        else $error("interrupt while all sources masked");
endmodule : lael_event_latch_sva
bind lael_event_latch lael_event_latch_sva u_sva (.clk, .arst_n, .reg_rd, .reg_addr, .reg_rdata,
    .sys_alarm_ind_live, .line_alarm_ind_live, .pattern_sync_live, .amplitude_ovf_evt, .mask_a, .mask_b, .mask_c, .irq);

// File: verification/lael_event_latch_test.sv
// Self-checking bench for the alarm and event latch block.
`timescale 1ns/1ps
module lael_event_latch_test
    import lael_pkg::*;
;
    localparam int up_cyc = 20, down_cyc = 15, long_cyc = 50;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, irq;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata;
    logic [NUM_CH-1:0] overcurrent_live = '0, tx_clock_missing_live = '0, tx_loss_live = '0, sys_loss_live = '0;
    logic [NUM_CH-1:0] line_loss_live = '0, sys_alarm_ind_live = '0, line_alarm_ind_live = '0, pattern_sync_live = '0;
    logic [NUM_CH-1:0] loop_code_up_seen = '0, loop_code_down_seen = '0, auto_loopback_on = '0, amplitude_ovf_evt = '0;
    logic [NUM_CH-1:0] tx_jitter_fifo_evt = '0, rx_jitter_fifo_evt = '0, sys_bipolar_viol_evt = '0;
    logic [NUM_CH-1:0] line_bipolar_viol_evt = '0, sys_excess_zero_evt = '0, line_excess_zero_evt = '0;
    logic [NUM_CH-1:0] pattern_error_evt = '0, err_counter_ovf_evt = '0;
    logic [NUM_CH-1:0][7:0] mask_a = '1, mask_b = '1, mask_c = '1, edge_sel = '0;
    int error_cnt = 0, n_tests = 0;
    lael_event_latch #(.UP_SHORT_CYC(up_cyc), .DOWN_SHORT_CYC(down_cyc), .LONG_CYC(long_cyc)) DUT (.clk, .arst_n,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .overcurrent_live, .tx_clock_missing_live, .tx_loss_live,
        .sys_loss_live, .line_loss_live, .sys_alarm_ind_live, .line_alarm_ind_live, .pattern_sync_live,
        .loop_code_up_seen, .loop_code_down_seen, .auto_loopback_on, .amplitude_ovf_evt, .tx_jitter_fifo_evt,
        .rx_jitter_fifo_evt, .sys_bipolar_viol_evt, .line_bipolar_viol_evt, .sys_excess_zero_evt,
        .line_excess_zero_evt, .pattern_error_evt, .err_counter_ovf_evt, .mask_a, .mask_b, .mask_c, .edge_sel, .irq);
    initial begin
        forever #25 clk = ~clk;
    end
    // Inputs always move 1 ns after a rising edge, never on it.
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk8(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(logic got, logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic wr(logic [10:0] a, logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        tick();
        reg_wr = 0;
    endtask : wr
    task automatic rd(logic [10:0] a, logic [7:0] e);
        reg_rd = 1;
        reg_addr = a;
        tick();
        reg_rd = 0;
        // Read data stands until the next read, so one idle edge keeps back-to-back reads from abutting.
        tick();
        chk8(reg_rdata, e);
    endtask : rd
    task automatic t_map();
        sys_alarm_ind_live[0] = 1;
        pattern_sync_live[15] = 1;
        wr(11'h01F, 8'hFF);
        tick(2);
        rd(11'h01F, 8'h00);
        rd(11'h7DF, 8'h80);
        rd(11'h39F, 8'h20);
        rd(11'h7E1, 8'h80);
        rd(11'h023, 8'h00);
        rd(11'h022, 8'h00);
        chk1(irq, 1'b0);
    endtask : t_map
    task automatic t_alarm();
        sys_alarm_ind_live[1] = 1;
        pattern_sync_live[1] = 1;
        tick(4);
        rd(11'h01F, 8'hA0);
        rd(11'h021, 8'hA0);
        wr(11'h021, 8'h80);
        rd(11'h021, 8'h20);
        wr(11'h021, 8'h20);
        pattern_sync_live[1] = 0;
        tick(4);
        rd(11'h021, 8'h00);
        edge_sel[1][ES_ALARM] = 1;
        line_alarm_ind_live[1] = 1;
        sys_alarm_ind_live[1] = 0;
        tick(4);
        rd(11'h01F, 8'h40);
        rd(11'h021, 8'hC0);
        wr(11'h021, 8'hFF);
        rd(11'h021, 8'h00);
        edge_sel[1] = 8'h20;
        pattern_sync_live[1] = 1;
        tick(4);
        wr(11'h021, 8'hFF);
        pattern_sync_live[1] = 0;
        tick(4);
        rd(11'h021, 8'h20);
        wr(11'h021, 8'hFF);
    endtask : t_alarm
    task automatic t_loss();
        overcurrent_live[1] = 1;
        line_loss_live[1] = 1;
        tick(4);
        rd(11'h020, 8'h11);
        wr(11'h020, 8'h11);
        overcurrent_live[1] = 0;
        line_loss_live[1] = 0;
        tick(4);
        rd(11'h020, 8'h00);
        {overcurrent_live[1], tx_clock_missing_live[1], tx_loss_live[1], sys_loss_live[1]} = '1;
        tick(4);
        rd(11'h020, 8'h1E);
        wr(11'h020, 8'hFF);
        edge_sel[1] = 8'h1E;
        {overcurrent_live[1], tx_clock_missing_live[1], tx_loss_live[1], sys_loss_live[1]} = '0;
        tick(4);
        rd(11'h020, 8'h1E);
        wr(11'h020, 8'hFF);
    endtask : t_loss
    task automatic t_evt();
        mask_a[1] = 8'h7F;
        amplitude_ovf_evt[1] = 1;
        tick();
        amplitude_ovf_evt[1] = 0;
        tick(3);
        chk1(irq, 1'b1);
        rd(11'h020, 8'h80);
        mask_a[1] = 8'hFF;
        tick(3);
        chk1(irq, 1'b0);
        {tx_jitter_fifo_evt[1], rx_jitter_fifo_evt[1], sys_bipolar_viol_evt[1], line_bipolar_viol_evt[1]} = '1;
        {sys_excess_zero_evt[1], line_excess_zero_evt[1], pattern_error_evt[1], err_counter_ovf_evt[1]} = '1;
        tick();
        {tx_jitter_fifo_evt[1], rx_jitter_fifo_evt[1], sys_bipolar_viol_evt[1], line_bipolar_viol_evt[1]} = '0;
        {sys_excess_zero_evt[1], line_excess_zero_evt[1], pattern_error_evt[1], err_counter_ovf_evt[1]} = '0;
        tick(2);
        rd(11'h020, 8'hE0);
        rd(11'h022, 8'h3F);
        mask_c[1] = 8'h00;
        tick(3);
        chk1(irq, 1'b1);
        wr(11'h022, 8'hFF);
        tick(3);
        chk1(irq, 1'b0);
        mask_c[1] = 8'hFF;
        pattern_error_evt[1] = 1;
        wr(11'h022, 8'h02);
        pattern_error_evt[1] = 0;
        rd(11'h022, 8'h02);
        wr(11'h022, 8'h02);
        rd(11'h022, 8'h00);
    endtask : t_evt
    task automatic t_loop();
        loop_code_up_seen[2] = 1;
        tick(up_cyc - 5);
        rd(11'h05F, 8'h00);
        tick(8);
        rd(11'h05F, 8'h02);
        rd(11'h061, 8'h02);
        loop_code_up_seen[2] = 0;
        auto_loopback_on[2] = 1;
        loop_code_down_seen[2] = 1;
        wr(11'h061, 8'hFF);
        tick(down_cyc + 5);
        rd(11'h05F, 8'h00);
        tick(long_cyc - down_cyc);
        rd(11'h05F, 8'h01);
        wr(11'h061, 8'hFF);
        edge_sel[2] = 8'h01;
        loop_code_down_seen[2] = 0;
        tick(4);
        rd(11'h061, 8'h01);
    endtask : t_loop
    task automatic stop_test();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // The run needs a few hundred cycles; two thousand leaves margin without hiding a hang.
    initial begin
        #(50 * 2000);
        error_cnt++;
        stop_test();
    end
    initial begin
        tick(20);
        arst_n = 1;
        t_map();
        t_alarm();
        t_loss();
        t_evt();
        t_loop();
        stop_test();
    end
endmodule : lael_event_latch_test
